/* core/rsq_consts.svh */
// Register map, field positions, reset values and timing figures of the regulator sequencer
`ifndef RSQ_CONSTS_SVH
`define RSQ_CONSTS_SVH

`define RSQ_CLK_MHZ    100
`define RSQ_SETTLE_US  100
`define RSQ_CFG_US     100
`define RSQ_SS_US      2000
`define RSQ_HS_US      427
`define RSQ_RAMP_STEPS 256

`define RSQ_SRC_ADDR   8'h10
`define RSQ_MASK_ADDR  8'h11
`define RSQ_SRC_RST    8'h00
`define RSQ_MASK_RST   8'h0f

`define RSQ_BIT_OCP    0
`define RSQ_BIT_THS    1
`define RSQ_BIT_HS     2
`define RSQ_BIT_OVP    3
`define RSQ_BIT_PG     4

`define RSQ_I2C_BASE   5'h18

`endif

/* core/rsq_i2c_slave.sv */
// Two-wire serial slave: address, register pointer, then data written or read
`timescale 1ns/1ps
`include "rsq_consts.svh"
module rsq_i2c_slave
(
	input  logic       clk,
	input  logic       reset,
	input  logic       enable,
	input  logic [1:0] addr_sel,
	input  logic       scl_f,
	input  logic       sda_f,
	output logic       sda_oe_n,
	rsq_reg_if.bus     rb
);
	rsq_pkg::rsq_i2c_t st_q;
	logic [3:0]        cnt_q;
	logic [7:0]        sh_q;
	logic [7:0]        tx_q;
	logic [7:0]        ptr_q;
	logic [7:0]        wdata_q;
	logic              rw_q;
	logic              drv_q;
	logic              wr_q;
	logic              scl_p_q;
	logic              sda_p_q;
	logic [6:0]        my_addr;
	logic              scl_rise;
	logic              scl_fall;
	logic              start;
	logic              stop;

	assign my_addr  = {`RSQ_I2C_BASE, addr_sel};
	assign scl_rise = scl_f & ~scl_p_q;
	assign scl_fall = ~scl_f & scl_p_q;
	assign start    = scl_f & scl_p_q & sda_p_q & ~sda_f;
	assign stop     = scl_f & scl_p_q & ~sda_p_q & sda_f;
	assign sda_oe_n = ~drv_q;
	assign rb.ptr   = ptr_q;
	assign rb.wdata = wdata_q;
	assign rb.wr    = wr_q;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_p_q <= scl_f;
			sda_p_q <= sda_f;
		end
	end

	// Held idle while disabled so the pins stay released
	always_ff @(posedge clk)
	begin
		if (reset || !enable)
		begin
			st_q    <= rsq_pkg::I2C_IDLE;
			cnt_q   <= 4'h0;
			sh_q    <= 8'h00;
			tx_q    <= 8'h00;
			ptr_q   <= 8'h00;
			wdata_q <= 8'h00;
			rw_q    <= 1'b0;
			drv_q   <= 1'b0;
			wr_q    <= 1'b0;
		end
		else
		begin
			wr_q <= 1'b0;
			if (start)
			begin
				st_q  <= rsq_pkg::I2C_ADDR;
				// The clock fall that closes the start is no data bit: it wraps to zero
				cnt_q <= 4'hf;
				drv_q <= 1'b0;
			end
			else if (stop)
			begin
				st_q  <= rsq_pkg::I2C_IDLE;
				drv_q <= 1'b0;
			end
			else if (st_q != rsq_pkg::I2C_IDLE)
			begin
				if (scl_rise && cnt_q < 4'h8 && st_q != rsq_pkg::I2C_RD)
					sh_q <= {sh_q[6:0], sda_f};
				if (scl_rise && cnt_q == 4'h8 && st_q == rsq_pkg::I2C_RD && sda_f)
					st_q <= rsq_pkg::I2C_IDLE;
				if (scl_fall)
				begin
					if (cnt_q == 4'h7)
					begin
						cnt_q <= 4'h8;
						case (st_q)
							rsq_pkg::I2C_ADDR:
							begin
								drv_q <= (sh_q[7:1] == my_addr);
								rw_q  <= sh_q[0];
								if (sh_q[7:1] != my_addr)
									st_q <= rsq_pkg::I2C_IDLE;
							end
							rsq_pkg::I2C_PTR:
							begin
								ptr_q <= sh_q;
								drv_q <= 1'b1;
							end
							rsq_pkg::I2C_WR:
							begin
								wdata_q <= sh_q;
								wr_q    <= 1'b1;
								drv_q   <= 1'b1;
							end
							default: drv_q <= 1'b0;
						endcase
					end
					else if (cnt_q == 4'h8)
					begin
						cnt_q <= 4'h0;
						if (st_q == rsq_pkg::I2C_ADDR)
							st_q <= rw_q ? rsq_pkg::I2C_RD : rsq_pkg::I2C_PTR;
						else if (st_q == rsq_pkg::I2C_PTR)
							st_q <= rsq_pkg::I2C_WR;
						if ((st_q == rsq_pkg::I2C_ADDR && rw_q) || st_q == rsq_pkg::I2C_RD)
						begin
							tx_q  <= {rb.rdata[6:0], 1'b0};
							drv_q <= ~rb.rdata[7];
						end
						else
							drv_q <= 1'b0;
					end
					else
					begin
						cnt_q <= cnt_q + 4'h1;
						if (st_q == rsq_pkg::I2C_RD)
						begin
							drv_q <= ~tx_q[7];
							tx_q  <= {tx_q[6:0], 1'b0};
						end
					end
				end
			end
		end
	end
endmodule

/* core/rsq_pkg.sv */
// Types shared by the regulator sequencer modules
package rsq_pkg;

	typedef enum logic [2:0]
	{
		ST_OFF      = 3'h0,
		ST_SETTLE   = 3'h1,
		ST_WAIT_LOW = 3'h3,
		ST_CFG      = 3'h2,
		ST_SS       = 3'h6,
		ST_RUN      = 3'h7,
		ST_LATCH    = 3'h5
	} rsq_seq_t;

	typedef enum logic [2:0]
	{
		I2C_IDLE = 3'h0,
		I2C_ADDR = 3'h1,
		I2C_PTR  = 3'h3,
		I2C_WR   = 3'h2,
		I2C_RD   = 3'h6
	} rsq_i2c_t;

endpackage

/* core/rsq_reg_if.sv */
// Register access path between the serial slave and the register file
`timescale 1ns/1ps
interface rsq_reg_if;
	logic [7:0] ptr;
	logic [7:0] wdata;
	logic       wr;
	logic [7:0] rdata;
	modport bus (output ptr, output wdata, output wr, input rdata);
	modport regs (input ptr, input wdata, input wr, output rdata);
endinterface

/* core/rsq_sequencer.sv */
// Startup/shutdown sequencer, fault latching, status register and indicator pin
// Behaviour
// - Enable with good supplies: settle about 100us with output discharge on.
// - After settle and output below 1.5V: discharge off, sense configuration resistor.
// - Configuration read takes about 100us; then serial interface on and soft-start begin in the same cycle.
// - Enable during leftover discharge waits until that discharge has finished.
// - Soft-start of 2ms ramps the reference from zero to target.
// - Below 2V output: 300kHz and reduced current limit; above: normal values.
// - Hard-short detection off during soft-start, on when the soft-start timer expires.
// - Enable low: stop switching, reset all registers, turn discharge on.
// - Supply undervoltage: output and serial interface off, registers held reset.
// - Thermal trip or current limit beyond 427us latches regulator off, registers kept.
// - Latched off stays off until enable, input supply or I/O supply is cycled.
// - Discharge on at every shutdown except thermal; off while regulating.
// - Power-good and fault status readable at address 0x10.
// - Open-drain active-low indicator is NOR of unmasked status bits.
// - Mask bit at 0x11 hides its status bit from the indicator only.
// - Power-good clears below 85%, sets above 95%, holds in soft-start or change.
// - Fault bits set on their event, clear only by enable low or power cycle.
// - Mask resets to 0x0f; writing 0x10 passes faults, masks power-good.
`timescale 1ns/1ps
`include "rsq_consts.svh"
module rsq_sequencer #(
	parameter int SETTLE_CYC = `RSQ_SETTLE_US * `RSQ_CLK_MHZ,
	parameter int CFG_CYC    = `RSQ_CFG_US * `RSQ_CLK_MHZ,
	parameter int SS_CYC     = `RSQ_SS_US * `RSQ_CLK_MHZ,
	parameter int HS_CYC     = `RSQ_HS_US * `RSQ_CLK_MHZ
)
(
	input  logic       clk,
	input  logic       reset,
	input  logic       en_pin,
	input  logic       in_supply_ok,
	input  logic       io_supply_ok,
	input  logic       vout_lt_1v5,
	input  logic       vout_lt_2v,
	input  logic       vout_lt_85pct,
	input  logic       vout_gt_95pct,
	input  logic       thermal_trip,
	input  logic       ilim_hit,
	input  logic       ovp_event,
	input  logic       ocp_event,
	input  logic       dvs_active,
	input  logic [1:0] cfg_addr_sel,
	input  logic [1:0] cfg_ilim_sel,
	input  logic       cfg_ext_fb,
	input  logic [7:0] vref_target,
	input  logic       scl_in,
	input  logic       sda_in,
	output logic       sda_out,
	output logic       sda_oe_n,
	output logic       status_indicator_pin_n_out,
	output logic       status_indicator_pin_n_oe_n,
	output logic       regulator_on,
	output logic       discharge_on,
	output logic       i2c_active,
	output logic       cfg_sense_on,
	output logic [7:0] vref_ramp,
	output logic       low_freq_mode,
	output logic       reduced_current_limit,
	output logic       hard_short_detect_en,
	output logic [1:0] ilim_select,
	output logic       ext_feedback
);
	localparam int SS_TICK = (SS_CYC / `RSQ_RAMP_STEPS > 0) ? SS_CYC / `RSQ_RAMP_STEPS : 1;

	// ****************************************
	// Input synchronisation
	// ****************************************
	logic [18:0] raw;
	logic [18:0] filt;
	logic en_s, in_ok_s, io_ok_s, lt15_s, lt2_s, lt85_s, gt95_s;
	logic ths_s, ilim_s, ovp_s, ocp_s, dvs_s, scl_s, sda_s;
	logic [1:0] addr_sel_s;
	logic [1:0] ilim_sel_s;
	logic ext_fb_s;
	logic sup_ok;
	logic reg_rst;

	assign raw = {en_pin, in_supply_ok, io_supply_ok, vout_lt_1v5, vout_lt_2v,
		vout_lt_85pct, vout_gt_95pct, thermal_trip, ilim_hit, ovp_event, ocp_event,
		dvs_active, scl_in, sda_in, cfg_addr_sel, cfg_ilim_sel, cfg_ext_fb};
	assign {en_s, in_ok_s, io_ok_s, lt15_s, lt2_s, lt85_s, gt95_s, ths_s, ilim_s,
		ovp_s, ocp_s, dvs_s, scl_s, sda_s, addr_sel_s, ilim_sel_s, ext_fb_s} = filt;

	rsq_sync #(.W(19)) u_sync
	(
		.clk   (clk),
		.reset (reset),
		.d     (raw),
		.q     (filt)
	);

	assign sup_ok  = in_ok_s & io_ok_s;
	assign reg_rst = reset | ~en_s | ~sup_ok;

	// ****************************************
	// Sequencer
	// ****************************************
	rsq_pkg::rsq_seq_t state_q;
	rsq_pkg::rsq_seq_t state_d;
	logic [17:0] tmr_q;
	logic [15:0] hs_q;
	logic        hs_trip;
	logic        ths_latch_q;

	assign hs_trip = (hs_q == 16'(HS_CYC));

	always_comb
	begin
		state_d = state_q;
		if (!en_s || !sup_ok)
			state_d = rsq_pkg::ST_OFF;
		else if (ths_s && state_q != rsq_pkg::ST_OFF)
			state_d = rsq_pkg::ST_LATCH;
		else
			case (state_q)
				rsq_pkg::ST_OFF:
					if (lt15_s)
						state_d = rsq_pkg::ST_SETTLE;
				rsq_pkg::ST_SETTLE:
					if (tmr_q >= 18'(SETTLE_CYC - 1))
						state_d = rsq_pkg::ST_WAIT_LOW;
				rsq_pkg::ST_WAIT_LOW:
					if (lt15_s)
						state_d = rsq_pkg::ST_CFG;
				rsq_pkg::ST_CFG:
					if (tmr_q >= 18'(CFG_CYC - 1))
						state_d = rsq_pkg::ST_SS;
				rsq_pkg::ST_SS:
					if (tmr_q >= 18'(SS_CYC - 1))
						state_d = rsq_pkg::ST_RUN;
				rsq_pkg::ST_RUN:
					if (hs_trip || ocp_s)
						state_d = rsq_pkg::ST_LATCH;
				rsq_pkg::ST_LATCH:
					state_d = rsq_pkg::ST_LATCH;
				default:
					state_d = rsq_pkg::ST_OFF;
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_q <= rsq_pkg::ST_OFF;
			tmr_q   <= 18'h00000;
		end
		else
		begin
			state_q <= state_d;
			tmr_q   <= (state_d != state_q) ? 18'h00000 : tmr_q + 18'h00001;
		end
	end

	// Current-limit timer only runs once detection is armed
	always_ff @(posedge clk)
	begin
		if (reset || state_q != rsq_pkg::ST_RUN || !ilim_s)
			hs_q <= 16'h0000;
		else if (!hs_trip)
			hs_q <= hs_q + 16'h0001;
	end

	// Thermal latch-off leaves the output undischarged
	always_ff @(posedge clk)
	begin
		if (reset || state_q == rsq_pkg::ST_OFF)
			ths_latch_q <= 1'b0;
		else if (state_d == rsq_pkg::ST_LATCH && state_q != rsq_pkg::ST_LATCH)
			ths_latch_q <= ths_s;
	end

	// ****************************************
	// Regulator controls
	// ****************************************
	logic       reg_on_q, dis_q, i2c_q, sense_q, low_v_q, hsd_q;
	logic [7:0] vref_q;
	logic [7:0] ramp_q;
	logic [17:0] rtick_q;
	logic [1:0] ilim_sel_q;
	logic       ext_fb_q;
	logic [15:0] prod;

	assign prod = 16'(vref_target) * 16'(ramp_q);

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			reg_on_q <= 1'b0;
			dis_q    <= 1'b0;
			i2c_q    <= 1'b0;
			sense_q  <= 1'b0;
			low_v_q  <= 1'b0;
			hsd_q    <= 1'b0;
		end
		else
		begin
			reg_on_q <= state_q == rsq_pkg::ST_SS || state_q == rsq_pkg::ST_RUN;
			i2c_q    <= sup_ok && (state_q == rsq_pkg::ST_SS || state_q == rsq_pkg::ST_RUN
				|| state_q == rsq_pkg::ST_LATCH);
			sense_q  <= state_q == rsq_pkg::ST_CFG;
			low_v_q  <= (state_q == rsq_pkg::ST_SS || state_q == rsq_pkg::ST_RUN) && lt2_s;
			hsd_q    <= state_q == rsq_pkg::ST_RUN;
			case (state_q)
				rsq_pkg::ST_OFF:      dis_q <= !lt15_s;
				rsq_pkg::ST_SETTLE:   dis_q <= 1'b1;
				rsq_pkg::ST_WAIT_LOW: dis_q <= !lt15_s;
				rsq_pkg::ST_LATCH:    dis_q <= !ths_latch_q;
				default:              dis_q <= 1'b0;
			endcase
		end
	end

	// Reference ramp: target scaled by a step count that advances every SS_TICK cycles
	always_ff @(posedge clk)
	begin
		if (reset || state_q != rsq_pkg::ST_SS)
		begin
			rtick_q <= 18'h00000;
			ramp_q  <= 8'h00;
		end
		else if (rtick_q >= 18'(SS_TICK - 1))
		begin
			rtick_q <= 18'h00000;
			if (ramp_q != 8'hff)
				ramp_q <= ramp_q + 8'h01;
		end
		else
			rtick_q <= rtick_q + 18'h00001;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			vref_q <= 8'h00;
		else if (state_q == rsq_pkg::ST_SS)
			vref_q <= prod[15:8];
		else if (state_q == rsq_pkg::ST_RUN)
			vref_q <= vref_target;
		else
			vref_q <= 8'h00;
	end

	always_ff @(posedge clk)
	begin
		if (reg_rst)
		begin
			ilim_sel_q <= 2'h0;
			ext_fb_q   <= 1'b0;
		end
		else if (state_q == rsq_pkg::ST_CFG && state_d == rsq_pkg::ST_SS)
		begin
			ilim_sel_q <= ilim_sel_s;
			ext_fb_q   <= ext_fb_s;
		end
	end

	assign regulator_on          = reg_on_q;
	assign discharge_on          = dis_q;
	assign i2c_active            = i2c_q;
	assign cfg_sense_on          = sense_q;
	assign vref_ramp             = vref_q;
	assign low_freq_mode         = low_v_q;
	assign reduced_current_limit = low_v_q;
	assign hard_short_detect_en  = hsd_q;
	assign ilim_select           = ilim_sel_q;
	assign ext_feedback          = ext_fb_q;

	// ****************************************
	// Status registers and indicator pin
	// ****************************************
	rsq_reg_if  rif ();
	logic [7:0] src_q;
	logic [7:0] mask_q;
	logic       ind_oe_n_q;

	rsq_i2c_slave u_i2c
	(
		.clk      (clk),
		.reset    (reset),
		.enable   (i2c_q),
		.addr_sel (addr_sel_s),
		.scl_f    (scl_s),
		.sda_f    (sda_s),
		.sda_oe_n (sda_oe_n),
		.rb       (rif.bus)
	);
	assign sda_out = 1'b0;

	always_comb
	begin
		case (rif.ptr)
			`RSQ_SRC_ADDR:  rif.rdata = src_q;
			`RSQ_MASK_ADDR: rif.rdata = mask_q;
			default:        rif.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reg_rst)
			mask_q <= `RSQ_MASK_RST;
		else if (rif.wr && rif.ptr == `RSQ_MASK_ADDR)
			mask_q <= rif.wdata;
	end

	// Fault bits have no clear path other than the enable-low or power-cycle reset
	always_ff @(posedge clk)
	begin
		if (reg_rst)
			src_q <= `RSQ_SRC_RST;
		else
		begin
			if (ovp_s && state_q != rsq_pkg::ST_OFF)
				src_q[`RSQ_BIT_OVP] <= 1'b1;
			if (state_q == rsq_pkg::ST_RUN && hs_trip)
				src_q[`RSQ_BIT_HS] <= 1'b1;
			if (ths_s && state_q != rsq_pkg::ST_OFF)
				src_q[`RSQ_BIT_THS] <= 1'b1;
			if (state_q == rsq_pkg::ST_RUN && ocp_s)
				src_q[`RSQ_BIT_OCP] <= 1'b1;
			if (state_q == rsq_pkg::ST_RUN && !dvs_s)
			begin
				if (gt95_s)
					src_q[`RSQ_BIT_PG] <= 1'b1;
				else if (lt85_s)
					src_q[`RSQ_BIT_PG] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			ind_oe_n_q <= 1'b1;
		else
			ind_oe_n_q <= ~|(src_q & ~mask_q);
	end

	assign status_indicator_pin_n_out  = 1'b0;
	assign status_indicator_pin_n_oe_n = ind_oe_n_q;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	AST_SETTLE_DISCHARGE: assert property (state_q == rsq_pkg::ST_SETTLE |=> discharge_on)
		else $error("discharge off during settle");
	AST_CFG_NO_DISCHARGE: assert property (state_q == rsq_pkg::ST_CFG |-> !discharge_on)
		else $error("discharge on during configuration read");
	AST_I2C_AFTER_CFG: assert property ($rose(i2c_active) |-> $past(state_q) == rsq_pkg::ST_SS)
		else $error("serial interface enabled before configuration read");
	AST_WAIT_DISCHARGE: assert property ((state_q == rsq_pkg::ST_OFF && !lt15_s)
		|=> state_q != rsq_pkg::ST_SETTLE)
		else $error("startup began during discharge");
	AST_LOW_FREQ: assert property (low_freq_mode |-> $past(lt2_s))
		else $error("low-frequency mode without low output");
	AST_HS_DETECT: assert property (hard_short_detect_en |-> $past(state_q) == rsq_pkg::ST_RUN)
		else $error("hard-short detection armed outside run");
	AST_EN_LOW_RESET: assert property ((!en_s && state_q != rsq_pkg::ST_OFF)
		|=> (state_q == rsq_pkg::ST_OFF && mask_q == `RSQ_MASK_RST))
		else $error("enable low did not shut down and reset");
	AST_HS_LATCH: assert property ((state_q == rsq_pkg::ST_RUN && hs_trip && en_s && sup_ok
		&& !ths_s) |=> (state_q == rsq_pkg::ST_LATCH && src_q[`RSQ_BIT_HS]))
		else $error("hard short did not latch off");
	AST_RUN_NO_DISCHARGE: assert property (state_q == rsq_pkg::ST_RUN |=> !discharge_on)
		else $error("discharge on while regulating");
	AST_INDICATOR: assert property (1'b1 |=> status_indicator_pin_n_oe_n
		== !$past(|(src_q & ~mask_q)))
		else $error("indicator disagrees with unmasked status");
	AST_PG_HOLD: assert property ((state_q == rsq_pkg::ST_SS && en_s && sup_ok)
		|=> $stable(src_q[`RSQ_BIT_PG]))
		else $error("power-good changed during soft-start");

	COV_RUN: cover property (state_q == rsq_pkg::ST_RUN);
	COV_LATCH: cover property (state_q == rsq_pkg::ST_LATCH);
	COV_IND: cover property ($fell(status_indicator_pin_n_oe_n));
endmodule

/* core/rsq_sync.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module rsq_sync #(parameter int W = 1)
(
	input  logic         clk,
	input  logic         reset,
	input  logic [W-1:0] d,
	output logic [W-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic q_q;

			assign q[i] = q_q;
			always_ff @(posedge clk)
			begin
				if (reset)
				begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					q_q  <= 1'b0;
				end
				else
				begin
					s1_q <= d[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q)
						q_q <= s3_q;
				end
			end
		end
	endgenerate
endmodule

/* test/rsq_host_model.sv */
// Host model: two-wire bus master with the pulled-up data line resolved here
`timescale 1ns/1ps
module rsq_host_model #(parameter int HP = 10)
(
	input  logic clk,
	input  logic dev_sda_out,
	input  logic dev_sda_oe_n,
	output logic scl,
	output logic sda
);
	logic m_sda;

	// Pull-up: a released line reads high, never the last driven value
	assign sda = m_sda & (dev_sda_oe_n | dev_sda_out);

	initial
	begin
		scl = 1'b1;
		m_sda = 1'b1;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic bit_io(input logic b, output logic r);
		m_sda <= b;
		hold(HP);
		scl <= 1'b1;
		hold(HP);
		r = sda;
		scl <= 1'b0;
		hold(1);
	endtask

	// Serves both first and repeated start
	task automatic start();
		@(posedge clk);
		m_sda <= 1'b1;
		hold(HP);
		scl <= 1'b1;
		hold(HP);
		m_sda <= 1'b0;
		hold(HP);
		scl <= 1'b0;
		hold(HP);
	endtask

	task automatic stop();
		m_sda <= 1'b0;
		hold(HP);
		scl <= 1'b1;
		hold(HP);
		m_sda <= 1'b1;
		hold(HP);
	endtask

	task automatic tx(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
		output logic ok);
		logic k0, k1, k2;
		start();
		tx({a, 1'b0}, k0);
		tx(p, k1);
		tx(d, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask

	// Single byte read, closed by a not-acknowledge
	task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
		output logic ok);
		logic k0, k1, k2, r;
		start();
		tx({a, 1'b0}, k0);
		tx(p, k1);
		start();
		tx({a, 1'b1}, k2);
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(1'b1, r);
		stop();
		ok = k0 & k1 & k2;
	endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench: sequencing, shutdown, faults, status register and indicator pin
`timescale 1ns/1ps
`include "rsq_consts.svh"
module tb_top;
	localparam int SET_C = 20;
	localparam int CFG_C = 20;
	localparam int SS_C  = 512;
	localparam int HS_C  = 30;
	logic       clk, reset, en_pin, in_supply_ok, io_supply_ok, vout_lt_1v5, vout_lt_2v;
	logic       vout_lt_85pct, vout_gt_95pct, thermal_trip, ilim_hit, ovp_event, ocp_event;
	logic       dvs_active, cfg_ext_fb, scl_in, sda_in, sda_out, sda_oe_n;
	logic       status_indicator_pin_n_out, status_indicator_pin_n_oe_n, regulator_on;
	logic       discharge_on, i2c_active, cfg_sense_on, low_freq_mode, reduced_current_limit;
	logic       hard_short_detect_en, ext_feedback;
	logic [1:0] cfg_addr_sel, cfg_ilim_sel, ilim_select;
	logic [7:0] vref_target, vref_ramp;
	int         err_total, checks, n;

	rsq_sequencer #(.SETTLE_CYC(SET_C), .CFG_CYC(CFG_C), .SS_CYC(SS_C), .HS_CYC(HS_C)) dut
	(.clk, .reset, .en_pin, .in_supply_ok, .io_supply_ok, .vout_lt_1v5, .vout_lt_2v,
	 .vout_lt_85pct, .vout_gt_95pct, .thermal_trip, .ilim_hit, .ovp_event, .ocp_event,
	 .dvs_active, .cfg_addr_sel, .cfg_ilim_sel, .cfg_ext_fb, .vref_target, .scl_in, .sda_in,
	 .sda_out, .sda_oe_n, .status_indicator_pin_n_out, .status_indicator_pin_n_oe_n,
	 .regulator_on, .discharge_on, .i2c_active, .cfg_sense_on, .vref_ramp, .low_freq_mode,
	 .reduced_current_limit, .hard_short_detect_en, .ilim_select, .ext_feedback);
	rsq_host_model host (.clk, .dev_sda_out(sda_out), .dev_sda_oe_n(sda_oe_n), .scl(scl_in),
		.sda(sda_in));

	always #5 clk = ~clk;

	// ****************************************
	// Checking helpers
	// ****************************************
	task automatic fail(input string m);
		err_total++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task automatic chk_bit(input logic g, input logic e, input string m);
		checks++;
		if (g !== e) fail(m);
	endtask
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
		checks++;
		if (g !== e) fail(m);
	endtask
	task automatic chk_cnt(input int g, input int lo, input int hi, input string m);
		checks++;
		if (g < lo || g > hi) fail(m);
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	function automatic logic exp_oe_n(input logic [7:0] st, input logic [7:0] mk);
		return ~|(st & ~mk);
	endfunction
	function automatic logic sig(input int k);
		case (k)
			0: return regulator_on;
			1: return cfg_sense_on;
			default: return discharge_on;
		endcase
	endfunction
	// Counts settled cycles until the chosen output reaches the level
	task automatic wait_lvl(input int k, input logic v, input int lim, output int c);
		c = 0;
		while (sig(k) !== v)
		begin
			@(negedge clk);
			c++;
			if (c > lim)
			begin
				fail("wait timed out");
				tally_and_finish();
			end
		end
	endtask
	task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
		logic [7:0] d;
		logic       ok;
		host.rd({`RSQ_I2C_BASE, cfg_addr_sel}, p, d, ok);
		chk_bit(ok, 1'b1, "read not acknowledged");
		chk_byte(d, e, "register read");
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] v);
		logic ok;
		host.wr({`RSQ_I2C_BASE, cfg_addr_sel}, p, v, ok);
		chk_bit(ok, 1'b1, "write not acknowledged");
	endtask

	// ****************************************
	// Sequences
	// ****************************************
	task automatic power_up(input bit pre);
		logic [7:0] prev;
		@(posedge clk);
		vref_target <= 8'($urandom_range(255, 1));
		cfg_addr_sel <= 2'($urandom);
		cfg_ilim_sel <= 2'($urandom);
		cfg_ext_fb <= 1'($urandom);
		vout_lt_2v <= 1'b1;
		vout_lt_1v5 <= !pre;
		en_pin <= 1'b1;
		if (pre)
		begin
			repeat (60) @(negedge clk);
			chk_bit(discharge_on & !cfg_sense_on, 1'b1, "start before discharge end");
			@(posedge clk);
			vout_lt_1v5 <= 1'b1;
		end
		else
			wait_lvl(2, 1'b1, 40, n);
		wait_lvl(1, 1'b1, SET_C + 60, n);
		if (!pre) chk_cnt(n, SET_C, SET_C + 2, "settle length");
		chk_bit(discharge_on | i2c_active, 1'b0, "discharge or bus on in sensing");
		wait_lvl(1, 1'b0, CFG_C + 2, n);
		chk_cnt(n, CFG_C, CFG_C, "sensing length");
		chk_bit(regulator_on & i2c_active, 1'b1, "no soft start");
		n = 0;
		prev = 8'h00;
		while (hard_short_detect_en !== 1'b1 && n <= SS_C + 4)
		begin
			@(posedge clk);
			vout_lt_2v <= (n < SS_C / 2);
			@(negedge clk);
			n++;
			chk_bit(vref_ramp >= prev, 1'b1, "ramp fell");
			prev = vref_ramp;
			if (n == 20) chk_bit(low_freq_mode & reduced_current_limit, 1'b1, "low out");
			if (n == SS_C / 2 + 10) chk_bit(low_freq_mode | reduced_current_limit, 1'b0, "hi");
		end
		chk_cnt(n, SS_C, SS_C, "soft start length");
		chk_byte(vref_ramp, vref_target, "final reference");
		chk_byte({5'h00, ilim_select, ext_feedback}, {5'h00, cfg_ilim_sel, cfg_ext_fb}, "cfg");
	endtask

	task automatic power_down();
		@(posedge clk);
		en_pin <= 1'b0;
		vout_lt_1v5 <= 1'b0;
		repeat (8) @(negedge clk);
		chk_bit(regulator_on | i2c_active, 1'b0, "still on after enable low");
		chk_bit(discharge_on, 1'b1, "no discharge at shutdown");
		chk_bit(status_indicator_pin_n_oe_n, 1'b1, "indicator not cleared");
	endtask

	task automatic latch_wait(output int c);
		wait_lvl(0, 1'b0, HS_C + 12, c);
		repeat (2) @(negedge clk);
	endtask

	initial
	begin
		void'($urandom(24785));
		{clk, en_pin, vout_gt_95pct, thermal_trip, ilim_hit, ovp_event, ocp_event} = '0;
		{dvs_active, cfg_ext_fb, cfg_addr_sel, cfg_ilim_sel, vref_target} = '0;
		{reset, in_supply_ok, io_supply_ok, vout_lt_1v5, vout_lt_2v, vout_lt_85pct} = '1;
		err_total = 0;
		checks = 0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		chk_bit(status_indicator_pin_n_oe_n & sda_oe_n & !regulator_on, 1'b1, "reset state");
		chk_bit(sda_out | status_indicator_pin_n_out, 1'b0, "pin data not low");
		// Synchronisers still show zeros just after reset; let them flush first
		repeat (6) @(negedge clk);
		power_up(0);
		@(posedge clk);
		{vout_gt_95pct, vout_lt_85pct} <= 2'b10;
		repeat (8) @(negedge clk);
		rd_chk(`RSQ_SRC_ADDR, 8'h10);
		rd_chk(`RSQ_MASK_ADDR, 8'h0f);
		chk_bit(status_indicator_pin_n_oe_n, exp_oe_n(8'h10, 8'h0f), "indicator");
		wr(`RSQ_MASK_ADDR, 8'h10);
		wr(`RSQ_SRC_ADDR, 8'hff);
		rd_chk(8'h20, 8'h00);
		rd_chk(`RSQ_SRC_ADDR, 8'h10);
		chk_bit(status_indicator_pin_n_oe_n, exp_oe_n(8'h10, 8'h10), "masked");
		@(posedge clk);
		{dvs_active, vout_gt_95pct, vout_lt_85pct} <= 3'b101;
		repeat (8) @(negedge clk);
		rd_chk(`RSQ_SRC_ADDR, 8'h10);
		@(posedge clk);
		dvs_active <= 1'b0;
		repeat (8) @(negedge clk);
		rd_chk(`RSQ_SRC_ADDR, 8'h00);
		repeat (6)
		begin
			@(posedge clk);
			ilim_hit <= 1'b1;
			repeat ($urandom_range(HS_C - 5, 1)) @(posedge clk);
			ilim_hit <= 1'b0;
			repeat (10) @(posedge clk);
		end
		chk_bit(regulator_on, 1'b1, "short burst latched off");
		@(posedge clk);
		ovp_event <= 1'b1;
		// Pulses under two cycles are filtered by the input synchroniser
		repeat (3) @(posedge clk);
		ovp_event <= 1'b0;
		repeat (8) @(negedge clk);
		rd_chk(`RSQ_SRC_ADDR, 8'h08);
		chk_bit(status_indicator_pin_n_oe_n, exp_oe_n(8'h08, 8'h10), "fault pin");
		@(posedge clk);
		ilim_hit <= 1'b1;
		latch_wait(n);
		chk_cnt(n, HS_C, HS_C + 8, "hard short time");
		chk_bit(discharge_on & i2c_active, 1'b1, "hard short latch");
		@(posedge clk);
		ilim_hit <= 1'b0;
		rd_chk(`RSQ_SRC_ADDR, 8'h0c);
		rd_chk(`RSQ_MASK_ADDR, 8'h10);
		chk_bit(regulator_on, 1'b0, "left latch");
		power_down();
		power_up(1);
		rd_chk(`RSQ_MASK_ADDR, 8'h0f);
		@(posedge clk);
		thermal_trip <= 1'b1;
		latch_wait(n);
		chk_bit(discharge_on, 1'b0, "discharge in thermal");
		@(posedge clk);
		thermal_trip <= 1'b0;
		repeat (20) @(negedge clk);
		chk_bit(regulator_on, 1'b0, "thermal latch left");
		rd_chk(`RSQ_SRC_ADDR, 8'h02);
		power_down();
		power_up(1);
		@(posedge clk);
		ocp_event <= 1'b1;
		repeat (3) @(posedge clk);
		ocp_event <= 1'b0;
		latch_wait(n);
		chk_bit(discharge_on, 1'b1, "discharge after overcurrent");
		rd_chk(`RSQ_SRC_ADDR, 8'h01);
		power_down();
		for (int k = 0; k < 2; k++)
		begin
			power_up(1);
			@(posedge clk);
			{in_supply_ok, io_supply_ok, vout_lt_1v5} <= {k[0], !k[0], 1'b0};
			latch_wait(n);
			chk_bit(i2c_active, 1'b0, "bus on in undervoltage");
			chk_bit(discharge_on, 1'b1, "no discharge in undervoltage");
			@(posedge clk);
			{en_pin, in_supply_ok, io_supply_ok} <= 3'b011;
		end
		tally_and_finish();
	end
endmodule
